//--- logic/pbc_power_button_control.sv
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - when off, a debounced button press turns the supply on; guard idle
// - when on without acpi, a button press turns the supply off at once
// - on with acpi: press raises management interrupt, source, status, starts guard
// - status cleared in time keeps the supply on so suspend can follow
// - status still set when guard expires turns the supply off
// - with acpi, press held four seconds or more then released turns supply off
// - steady green while fully on and no fault code is set
// - green blinks at half a hertz while in s1 or s3 and no fault code is set
// - fault codes 2 to 10 shown as red blink groups at one hertz
// - beeps match blinks, two second pause, beeping ends after five groups
// - magic packet, ring and pme wake from sleep, each with its own enable
// - detected ring wakes the system when ring wake is enabled
// - asserted pme wakes the system when pme wake is enabled
module pbc_power_button_control #(
   parameter int unsigned GUARD_CYC = pbc_pkg::GUARD_CYC,
   parameter int unsigned DEBOUNCE_CYC = pbc_pkg::DEBOUNCE_CYC,
   parameter int unsigned HALF_SEC_CYC = pbc_pkg::HALF_SEC_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic button_n_i,
   input wire logic ring_i,
   input wire logic pci_pme_n_i,
   input wire logic nic_pme_n_i,
   input wire logic supply_good_i,
   output logic supply_on_request_o,
   output logic mgmt_interrupt_n_o,
   output logic irq_o,
   output logic led_green_o,
   output logic led_red_o,
   output logic beep_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic btn_stable;
      logic [31:0] deb_cnt;
      logic ring_prev;
      logic [31:0] hold_cnt;
      logic guard_run;
      logic [31:0] guard_cnt;
      logic supply_on;
      logic [3:0] ctrl;
      logic sleep;
      logic [3:0] fault;
      logic [3:0] int_stat;
      logic [3:0] int_mask;
      logic smi_src;
      logic [31:0] tick_cnt;
      logic tick;
      logic green_ph;
      logic half_ph;
      pbc_pkg::pbc_led_st_t led_st;
      logic [3:0] blink_n;
      logic [2:0] pause_n;
      logic [2:0] rep_n;
      logic waitreq;
      logic [31:0] rdata;
      logic mgmt_n;
      logic irq;
      logic green;
      logic red;
      logic beep;
   } pbc_state_t;

   pbc_state_t st_ff;
   pbc_state_t nxt_st;

   logic btn_s;
   logic ring_s;
   logic pme_s;
   logic nic_s;
   logic good_s;
   logic btn_fall;
   logic btn_rise;
   logic wake;
   logic wr_go;
   logic rd_go;
   logic fault_go;

   assign btn_s = st_ff.sync2[0];
   assign ring_s = st_ff.sync2[1];
   assign pme_s = ~st_ff.sync2[2];
   assign nic_s = ~st_ff.sync2[3];
   assign good_s = st_ff.sync2[4];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      btn_fall = 1'b0;
      btn_rise = 1'b0;
      wake = 1'b0;
      fault_go = 1'b0;
      // first stage feeds only the second stage
      nxt_st.sync1 = {supply_good_i, nic_pme_n_i, pci_pme_n_i, ring_i, button_n_i};
      nxt_st.sync2 = st_ff.sync1;

      // a level must stay put for the whole window before it is believed
      if (btn_s == st_ff.btn_stable) begin
         nxt_st.deb_cnt = 32'h0;
      end else if (st_ff.deb_cnt >= DEBOUNCE_CYC - 1) begin
         nxt_st.deb_cnt = 32'h0;
         nxt_st.btn_stable = btn_s;
         btn_fall = st_ff.btn_stable;
         btn_rise = ~st_ff.btn_stable;
      end else begin
         nxt_st.deb_cnt = st_ff.deb_cnt + 32'h1;
      end

      // hold time, saturating so a long press cannot wrap
      if (st_ff.btn_stable) begin
         nxt_st.hold_cnt = 32'h0;
      end else if (st_ff.hold_cnt < GUARD_CYC) begin
         nxt_st.hold_cnt = st_ff.hold_cnt + 32'h1;
      end

      nxt_st.ring_prev = ring_s;
      if (st_ff.ctrl[pbc_pkg::CTRL_RING_BIT] && ring_s && !st_ff.ring_prev) begin
         wake = 1'b1;
      end
      if (st_ff.ctrl[pbc_pkg::CTRL_PME_BIT] && pme_s) begin
         wake = 1'b1;
      end
      // the controller reports a magic packet on its own pme line
      if (st_ff.ctrl[pbc_pkg::CTRL_MAGIC_BIT] && nic_s) begin
         wake = 1'b1;
      end

      // ---- register bus: one wait cycle, then the access completes
      rd_go = avs_read_i && !st_ff.waitreq;
      wr_go = avs_write_i && !st_ff.waitreq && avs_byteenable_i[0];
      nxt_st.waitreq = !((avs_read_i || avs_write_i) && st_ff.waitreq);
      if (avs_address_i == pbc_pkg::CTRL_OFF) begin
         nxt_st.rdata = {28'h0, st_ff.ctrl};
      end else if (avs_address_i == pbc_pkg::SLEEP_OFF) begin
         nxt_st.rdata = {31'h0, st_ff.sleep};
      end else if (avs_address_i == pbc_pkg::FAULT_OFF) begin
         nxt_st.rdata = {28'h0, st_ff.fault};
      end else if (avs_address_i == pbc_pkg::INT_STAT_OFF) begin
         nxt_st.rdata = {28'h0, st_ff.int_stat};
      end else if (avs_address_i == pbc_pkg::INT_MASK_OFF) begin
         nxt_st.rdata = {28'h0, st_ff.int_mask};
      end else if (avs_address_i == pbc_pkg::SMI_SRC_OFF) begin
         nxt_st.rdata = {31'h0, st_ff.smi_src};
      end else if (avs_address_i == pbc_pkg::STATE_OFF) begin
         nxt_st.rdata = {28'h0, st_ff.guard_run, st_ff.btn_stable, good_s, st_ff.supply_on};
      end else begin
         nxt_st.rdata = 32'h0;
      end
      if (rd_go) begin
         nxt_st.rdata = st_ff.rdata;
      end

      if (wr_go) begin
         if (avs_address_i == pbc_pkg::CTRL_OFF) begin
            nxt_st.ctrl = avs_writedata_i[3:0];
         end else if (avs_address_i == pbc_pkg::SLEEP_OFF) begin
            nxt_st.sleep = avs_writedata_i[0];
         end else if (avs_address_i == pbc_pkg::FAULT_OFF) begin
            // codes outside the table clear the display
            if (avs_writedata_i[3:0] >= pbc_pkg::FAULT_MIN && avs_writedata_i[3:0] <= pbc_pkg::FAULT_MAX) begin
               nxt_st.fault = avs_writedata_i[3:0];
               fault_go = 1'b1;
            end else begin
               nxt_st.fault = 4'h0;
            end
         end else if (avs_address_i == pbc_pkg::INT_STAT_OFF) begin
            nxt_st.int_stat = st_ff.int_stat & ~avs_writedata_i[3:0];
         end else if (avs_address_i == pbc_pkg::INT_MASK_OFF) begin
            nxt_st.int_mask = avs_writedata_i[3:0];
         end else if (avs_address_i == pbc_pkg::SMI_SRC_OFF) begin
            nxt_st.smi_src = st_ff.smi_src & ~avs_writedata_i[0];
         end
      end

      // ---- power control; hardware sets below win over a same-cycle clear
      if (!st_ff.supply_on) begin
         if (btn_fall || wake) begin
            nxt_st.supply_on = 1'b1;
            nxt_st.sleep = 1'b0;
         end
      end else if (!st_ff.ctrl[pbc_pkg::CTRL_ACPI_BIT]) begin
         if (btn_fall) begin
            nxt_st.supply_on = 1'b0;
         end
      end else begin
         if (btn_fall) begin
            nxt_st.smi_src = 1'b1;
            nxt_st.int_stat[pbc_pkg::EV_BUTTON_BIT] = 1'b1;
            nxt_st.guard_run = 1'b1;
            nxt_st.guard_cnt = 32'h0;
         end
         if (btn_rise && st_ff.hold_cnt >= GUARD_CYC) begin
            nxt_st.supply_on = 1'b0;
            nxt_st.int_stat[pbc_pkg::EV_HOLD_BIT] = 1'b1;
         end
         if (st_ff.guard_run && st_ff.guard_cnt >= GUARD_CYC - 1) begin
            nxt_st.supply_on = 1'b0;
            nxt_st.int_stat[pbc_pkg::EV_GUARD_BIT] = 1'b1;
         end
      end
      // any enabled wake ends sleep, with or without acpi handling
      if (wake) begin
         nxt_st.sleep = 1'b0;
         nxt_st.int_stat[pbc_pkg::EV_WAKE_BIT] = 1'b1;
      end

      if (st_ff.guard_run && !btn_fall) begin
         nxt_st.guard_cnt = st_ff.guard_cnt + 32'h1;
      end
      // a cleared status leaves the supply alone, letting software suspend
      if (!nxt_st.int_stat[pbc_pkg::EV_BUTTON_BIT] || !nxt_st.supply_on) begin
         nxt_st.guard_run = 1'b0;
         nxt_st.guard_cnt = 32'h0;
      end

      // ---- half-second time base shared by all indicator patterns
      nxt_st.tick = 1'b0;
      if (st_ff.tick_cnt >= HALF_SEC_CYC - 1) begin
         nxt_st.tick_cnt = 32'h0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
      end

      if (st_ff.tick) begin
         case (st_ff.led_st)
            pbc_pkg::PBC_LED_ON: begin
               nxt_st.led_st = pbc_pkg::PBC_LED_OFF;
               nxt_st.blink_n = st_ff.blink_n + 4'h1;
            end
            pbc_pkg::PBC_LED_OFF: begin
               if (st_ff.blink_n >= st_ff.fault) begin
                  nxt_st.led_st = pbc_pkg::PBC_LED_PAUSE;
                  nxt_st.pause_n = 3'h0;
                  if (st_ff.rep_n < pbc_pkg::BEEP_CYCLES) begin
                     nxt_st.rep_n = st_ff.rep_n + 3'h1;
                  end
               end else begin
                  nxt_st.led_st = pbc_pkg::PBC_LED_ON;
               end
            end
            pbc_pkg::PBC_LED_PAUSE: begin
               if (st_ff.pause_n >= pbc_pkg::PAUSE_TICKS - 3'h1) begin
                  nxt_st.led_st = pbc_pkg::PBC_LED_ON;
                  nxt_st.blink_n = 4'h0;
               end else begin
                  nxt_st.pause_n = st_ff.pause_n + 3'h1;
               end
            end
            default: begin
               nxt_st.led_st = pbc_pkg::PBC_LED_IDLE;
            end
         endcase
         // green holds each phase for two ticks, one second, giving 0.5 hz
         nxt_st.half_ph = ~st_ff.half_ph;
         if (st_ff.half_ph) begin
            nxt_st.green_ph = ~st_ff.green_ph;
         end
      end
      // a new code restarts the pattern even when a tick falls on the same edge
      if (fault_go) begin
         nxt_st.led_st = pbc_pkg::PBC_LED_PAUSE;
         nxt_st.pause_n = 3'h0;
         nxt_st.rep_n = 3'h0;
      end
      if (nxt_st.fault == 4'h0) begin
         nxt_st.led_st = pbc_pkg::PBC_LED_IDLE;
      end

      // ---- outputs, registered
      nxt_st.red = nxt_st.led_st == pbc_pkg::PBC_LED_ON;
      nxt_st.beep = nxt_st.red && nxt_st.rep_n < pbc_pkg::BEEP_CYCLES;
      if (nxt_st.fault != 4'h0 || !nxt_st.supply_on) begin
         nxt_st.green = 1'b0;
      end else if (nxt_st.sleep) begin
         nxt_st.green = nxt_st.green_ph;
      end else begin
         nxt_st.green = 1'b1;
      end
      nxt_st.mgmt_n = ~nxt_st.smi_src;
      nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_ff <= '0;
         st_ff.sync1 <= 5'h1d;
         st_ff.sync2 <= 5'h1d;
         st_ff.btn_stable <= 1'b1;
         st_ff.supply_on <= pbc_pkg::SUPPLY_ON_RST;
         st_ff.ctrl <= pbc_pkg::CTRL_RST;
         st_ff.int_mask <= pbc_pkg::INT_MASK_RST;
         st_ff.led_st <= pbc_pkg::PBC_LED_IDLE;
         st_ff.waitreq <= 1'b1;
         st_ff.mgmt_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // supply on request feeds the supply, which gives main rails only while high
   assign supply_on_request_o = st_ff.supply_on;
   assign mgmt_interrupt_n_o = st_ff.mgmt_n;
   assign irq_o = st_ff.irq;
   assign led_green_o = st_ff.green;
   assign led_red_o = st_ff.red;
   assign beep_o = st_ff.beep;
   assign avs_readdata_o = st_ff.rdata;
   assign avs_waitrequest_o = st_ff.waitreq;
endmodule
`default_nettype wire

//--- logic/pbc_pkg.sv
`default_nettype none
package pbc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned GUARD_MS = 4000;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned HALF_SEC_MS = 500;
   localparam int unsigned GUARD_CYC = (CLK_HZ / 1000) * GUARD_MS;
   localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int unsigned HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
   localparam logic [2:0] PAUSE_TICKS = 3'h4;
   localparam logic [2:0] BEEP_CYCLES = 3'h5;
   localparam logic [3:0] FAULT_MIN = 4'h2;
   localparam logic [3:0] FAULT_MAX = 4'ha;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [4:0] CTRL_OFF = 5'h00;
   localparam logic [4:0] SLEEP_OFF = 5'h04;
   localparam logic [4:0] FAULT_OFF = 5'h08;
   localparam logic [4:0] INT_STAT_OFF = 5'h0c;
   localparam logic [4:0] INT_MASK_OFF = 5'h10;
   localparam logic [4:0] SMI_SRC_OFF = 5'h14;
   localparam logic [4:0] STATE_OFF = 5'h18;

   localparam int unsigned CTRL_ACPI_BIT = 0;
   localparam int unsigned CTRL_MAGIC_BIT = 1;
   localparam int unsigned CTRL_RING_BIT = 2;
   localparam int unsigned CTRL_PME_BIT = 3;
   localparam int unsigned EV_BUTTON_BIT = 0;
   localparam int unsigned EV_WAKE_BIT = 1;
   localparam int unsigned EV_GUARD_BIT = 2;
   localparam int unsigned EV_HOLD_BIT = 3;
   localparam int unsigned SMI_BUTTON_BIT = 0;

   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [3:0] INT_MASK_RST = 4'h0;
   localparam logic SUPPLY_ON_RST = 1'b0;

   typedef enum logic [3:0] {
      PBC_LED_IDLE = 4'h1,
      PBC_LED_ON = 4'h2,
      PBC_LED_OFF = 4'h4,
      PBC_LED_PAUSE = 4'h8
   } pbc_led_st_t;
endpackage
`default_nettype wire

//--- dv/pbc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_checker #(
   parameter int unsigned HALF_SEC_CYC = 10
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic button_n_i,
   input wire logic ring_i,
   input wire logic pci_pme_n_i,
   input wire logic nic_pme_n_i,
   input wire logic supply_on_request_o,
   input wire logic mgmt_interrupt_n_o,
   input wire logic led_green_o,
   input wire logic led_red_o,
   input wire logic beep_o
);
   // ----
   // helpers
   // ----
   logic [7:0] red_run_ff;
   logic [3:0] quiet_ff;
   // quiet_ff saturates so a long idle spell cannot wrap into a fake recent cause
   always_ff @(posedge clk_i) begin
      red_run_ff <= (!nrst_i || !led_red_o) ? 8'h00 : red_run_ff + 8'h01;
      if (!nrst_i || !button_n_i || ring_i || !pci_pme_n_i || !nic_pme_n_i) begin
         quiet_ff <= 4'h0;
      end else begin
         quiet_ff <= (quiet_ff == 4'hf) ? quiet_ff : quiet_ff + 4'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ----
   // properties
   // ----
   property p_wait_one; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
   property p_off_press; (button_n_i && !supply_on_request_o)[*8] ##1 !button_n_i[*8] |-> ##[0:4] supply_on_request_o; endproperty
   a_off_press: assert property (p_off_press) else $error("press while off did not turn supply on");
   property p_on_press; (button_n_i && supply_on_request_o)[*8] ##1 !button_n_i[*8] |-> ##[0:4] (!supply_on_request_o || !mgmt_interrupt_n_o); endproperty
   a_on_press: assert property (p_on_press) else $error("press while on gave no off and no interrupt");
   property p_smi_cause; $fell(mgmt_interrupt_n_o) |-> supply_on_request_o && !$past(button_n_i, 2); endproperty
   a_smi_cause: assert property (p_smi_cause) else $error("management interrupt without a press while on");
   property p_green_off; !supply_on_request_o && !$past(supply_on_request_o) && !$past(supply_on_request_o, 2) |-> !led_green_o; endproperty
   a_green_off: assert property (p_green_off) else $error("green lit with supply off");
   property p_red_len; $fell(led_red_o) |-> red_run_ff == 8'(HALF_SEC_CYC); endproperty
   a_red_len: assert property (p_red_len) else $error("red blink length wrong");
   property p_beep_red; beep_o |-> led_red_o; endproperty
   a_beep_red: assert property (p_beep_red) else $error("beep without red");
   property p_wake_cause; $rose(supply_on_request_o) |-> quiet_ff < 4'h8; endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("supply on with no recent cause");
endmodule
bind pbc_power_button_control pbc_checker #(.HALF_SEC_CYC(HALF_SEC_CYC)) pbc_checker_inst (
   .clk_i(clk_i),
   .nrst_i(nrst_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_waitrequest_o(avs_waitrequest_o),
   .button_n_i(button_n_i),
   .ring_i(ring_i),
   .pci_pme_n_i(pci_pme_n_i),
   .nic_pme_n_i(nic_pme_n_i),
   .supply_on_request_o(supply_on_request_o),
   .mgmt_interrupt_n_o(mgmt_interrupt_n_o),
   .led_green_o(led_green_o),
   .led_red_o(led_red_o),
   .beep_o(beep_o)
);
`default_nettype wire

//--- dv/pbc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_partner #(
   parameter int GOOD_DLY = 5
) (
   input wire logic clk_i,
   input wire logic supply_on_request_i,
   input wire logic press_i,
   input wire logic magic_i,
   output logic button_n_o,
   output logic nic_pme_n_o,
   output logic supply_good_o
);
   logic [7:0] good_cnt_ff;
   // contact is pulled up and grounded only while held
   assign button_n_o = !press_i;
   assign nic_pme_n_o = !magic_i;
   // a large GOOD_DLY models a slow supply
   always_ff @(posedge clk_i) begin
      if (!supply_on_request_i) begin
         good_cnt_ff <= 8'h00;
      end else if (good_cnt_ff != 8'(GOOD_DLY)) begin
         good_cnt_ff <= good_cnt_ff + 8'h01;
      end
   end
   assign supply_good_o = supply_on_request_i && good_cnt_ff == 8'(GOOD_DLY);
endmodule
`default_nettype wire

//--- dv/pbc_power_button_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_power_button_control_test;
   logic clk_i = 1'b0, nrst_i = 1'b0, rd = 1'b0, wr = 1'b0, ring = 1'b0, pme_n = 1'b1, press = 1'b0, magic = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wd = 32'h0, rdata, nr, nb, ng, lfsr = 32'h9ca1;
   logic [3:0] be = 4'hf;
   logic [63:0] t, expq[$];
   logic wait_o, son, smi_n, irq, grn, red, beep, btn_n, nic_n, good;
   int bad_count = 0, n_checks = 0, g;
   pbc_power_button_control #(.GUARD_CYC(200), .DEBOUNCE_CYC(4), .HALF_SEC_CYC(10)) pbc_power_button_control_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .button_n_i(btn_n), .ring_i(ring), .pci_pme_n_i(pme_n), .nic_pme_n_i(nic_n), .supply_good_i(good),
      .supply_on_request_o(son), .mgmt_interrupt_n_o(smi_n), .irq_o(irq), .led_green_o(grn), .led_red_o(red),
      .beep_o(beep));
   pbc_partner pbc_partner_inst (.clk_i(clk_i), .supply_on_request_i(son), .press_i(press), .magic_i(magic),
      .button_n_o(btn_n), .nic_pme_n_o(nic_n), .supply_good_o(good));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // ----
   // tasks
   // ----
   task automatic report_and_stop();
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic bus(logic w, logic [4:0] a, logic [31:0] d, logic [3:0] b);
      int n;
      n = 0;
      addr <= a;
      wd <= d;
      be <= b;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_o !== 1'b0 && n < 50);
      if (n >= 50) begin
         bad_count++;
         $display("ERROR waitrequest expected 0 seen %b", wait_o);
         report_and_stop();
      end else begin
         rd <= 1'b0;
         wr <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task automatic rdx(logic [4:0] a, logic [31:0] e, logic [31:0] m);
      expq.push_back({m, e});
      bus(1'b0, a, 32'h0, 4'hf);
   endtask
   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // press length is random so debounce is exercised at several widths
   task automatic tap();
      lfsr = lfsr_next(lfsr);
      press <= 1'b1;
      idle(10 + int'(lfsr[2:0]));
      press <= 1'b0;
      idle(12);
   endtask
   task automatic wake(int i);
      magic <= (i == 1);
      ring <= (i == 2);
      pme_n <= (i != 3);
      idle(6);
      {magic, ring, pme_n} <= 3'b001;
      idle(6);
   endtask
   task automatic count(int w);
      logic [2:0] p;
      p = {red, beep, grn};
      {nr, nb, ng} = '0;
      repeat (w) begin
         @(posedge clk_i);
         nr += 32'(red & !p[2]);
         nb += 32'(beep & !p[1]);
         ng += 32'(grn & !p[0]);
         p = {red, beep, grn};
      end
   endtask
   // ----
   // read results
   // ----
   always @(posedge clk_i) begin
      if (rd && !wait_o && expq.size() > 0) begin
         t = expq.pop_front();
         chk("readdata", t[31:0], rdata & t[63:32]);
      end
   end
   // ----
   // sequence
   // ----
   initial begin
      idle(3);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rdx(5'h00, 32'h0, 32'hf);
      rdx(5'h10, 32'h0, 32'hf);
      bus(1'b1, 5'h1c, 32'hf, 4'hf);
      rdx(5'h1c, 32'h0, 32'hffffffff);
      bus(1'b1, 5'h00, 32'h1, 4'he);
      rdx(5'h00, 32'h0, 32'hf);
      press <= 1'b1;
      idle(2);
      press <= 1'b0;
      idle(12);
      rdx(5'h18, 32'h0, 32'h1);
      tap();
      rdx(5'h18, 32'h3, 32'hb);
      tap();
      rdx(5'h18, 32'h0, 32'h1);
      tap();
      bus(1'b1, 5'h00, 32'h1, 4'hf);
      bus(1'b1, 5'h10, 32'h1, 4'hf);
      tap();
      chk("smi", 32'h0, 32'(smi_n));
      chk("irq", 32'h1, 32'(irq));
      rdx(5'h14, 32'h1, 32'h1);
      rdx(5'h18, 32'h9, 32'h9);
      bus(1'b1, 5'h0c, 32'h1, 4'hf);
      bus(1'b1, 5'h14, 32'h1, 4'hf);
      chk("irq", 32'h0, 32'(irq));
      chk("smi", 32'h1, 32'(smi_n));
      rdx(5'h18, 32'h1, 32'h9);
      idle(250);
      rdx(5'h18, 32'h1, 32'h1);
      tap();
      idle(200);
      rdx(5'h18, 32'h0, 32'h1);
      rdx(5'h0c, 32'h5, 32'h5);
      tap();
      bus(1'b1, 5'h0c, 32'hf, 4'hf);
      press <= 1'b1;
      idle(30);
      bus(1'b1, 5'h0c, 32'h1, 4'hf);
      idle(200);
      press <= 1'b0;
      idle(12);
      rdx(5'h18, 32'h0, 32'h1);
      rdx(5'h0c, 32'h8, 32'h8);
      bus(1'b1, 5'h0c, 32'hf, 4'hf);
      bus(1'b1, 5'h14, 32'h1, 4'hf);
      tap();
      chk("green", 32'h1, 32'(grn));
      bus(1'b1, 5'h04, 32'h1, 4'hf);
      count(80);
      chk("green blinks", 32'h2, ng);
      bus(1'b1, 5'h00, 32'h8, 4'hf);
      wake(3);
      rdx(5'h04, 32'h0, 32'h1);
      tap();
      for (int i = 1; i < 4; i++) begin
         for (int en = 0; en < 2; en++) begin
            bus(1'b1, 5'h00, 32'(en << i), 4'hf);
            bus(1'b1, 5'h0c, 32'hf, 4'hf);
            wake(i);
            rdx(5'h18, 32'(en), 32'h1);
            rdx(5'h0c, 32'(en << 1), 32'h2);
            if (en == 1) tap();
         end
      end
      for (int n = 2; n < 11; n++) begin
         g = (n == 2) ? 7 : 1;
         bus(1'b1, 5'h08, 32'(n), 4'hf);
         count(20 + g * (20 * n + 40));
         chk("red blinks", 32'(g * n), nr);
         chk("beeps", 32'((g > 5 ? 5 : g) * n), nb);
         bus(1'b1, 5'h08, 32'h0, 4'hf);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
